// [src/fbh_pkg.sv]
// constants and types for the flash bus host controller
// Overview of operation
// - Read: chip select, output enable low, write high
// - Unselected memories keep outputs disabled
// - Identifier read: other address lines held low (the host forces this only for FBH_OP_ID_HV, not for the read after 90h)
// - Program every bit zero before erasing
// - Command write: select low, write pulsed low
// - 20h twice starts erase
// - 40h then address/data write starts program
// - FFh twice cancels set-up
package fbh_pkg;
  localparam int          ADDR_W         = 17;
  localparam logic [7:0]  CMD_READ       = 8'h00;
  localparam logic [7:0]  CMD_ID         = 8'h90;
  localparam logic [7:0]  CMD_ERASE      = 8'h20;
  localparam logic [7:0]  CMD_ERASE_VFY  = 8'hA0;
  localparam logic [7:0]  CMD_PROG       = 8'h40;
  localparam logic [7:0]  CMD_PROG_VFY   = 8'hC0;
  localparam logic [7:0]  CMD_RESET      = 8'hFF;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  // bus phase lengths, in ns
  localparam int          SETUP_NS       = 100;
  localparam int          PULSE_NS       = 200;
  localparam int          HOLD_NS        = 100;
  localparam int          CLK_NS         = 100;
  localparam logic [3:0]  SETUP_CYC      = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  PULSE_CYC      = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  HOLD_CYC       = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [1:0] {
    FBH_OP_READ,
    FBH_OP_WRITE,
    FBH_OP_ID_HV
  } fbh_op_e;
  typedef enum logic [2:0] {
    FBH_IDLE,
    FBH_SETUP,
    FBH_PULSE,
    FBH_HOLD,
    FBH_DONE
  } fbh_state_e;
endpackage

// [src/fbh_host.sv]
// host-side controller driving the flash parallel bus pins
`timescale 1ns/100ps
module fbh_host
  import fbh_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic              req_valid_in,
  input  wire logic [1:0]        req_op_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [7:0]        req_data_in,
  input  wire logic              prog_supply_high_req_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [7:0]             rsp_data_out,
  output logic [ADDR_W-1:0]      address_lines_out,
  output logic                   chip_sel_n_out,
  output logic                   out_en_n_out,
  output logic                   write_n_out,
  output logic                   id_high_voltage_line_out,
  output logic                   program_supply_high_out,
  output logic [7:0]             data_pins_out,
  output logic                   data_pins_oe_out,
  input  wire logic [7:0]        data_pins_in
);
  fbh_state_e        state_reg;
  fbh_op_e           op_reg;
  logic [3:0]        cnt_reg;
  logic [7:0]        din_meta_reg;
  logic [7:0]        din_sync_reg;

  // two-flop sync of the data pins, sampled at end of read
  always_ff @(posedge sys_clk_in) begin
    din_meta_reg <= data_pins_in;
    din_sync_reg <= din_meta_reg;
  end

  assign req_ready_out = (state_reg == FBH_IDLE);

  // ************************************
  // bus sequencer
  // ************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= FBH_IDLE;
      op_reg    <= FBH_OP_READ;
      cnt_reg   <= 4'h0;
    end else begin
      case (state_reg)
        FBH_IDLE: begin
          if (req_valid_in) begin
            op_reg    <= fbh_op_e'(req_op_in);
            cnt_reg   <= SETUP_CYC;
            state_reg <= FBH_SETUP;
          end
        end
        FBH_SETUP: begin
          if (cnt_reg <= 4'h1) begin
            cnt_reg   <= PULSE_CYC;
            state_reg <= FBH_PULSE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        FBH_PULSE: begin
          if (cnt_reg <= 4'h1) begin
            cnt_reg   <= HOLD_CYC + 4'h2;
            state_reg <= FBH_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        FBH_HOLD: begin
          // extra two cycles let the read data cross the synchroniser
          if (cnt_reg <= 4'h1) begin
            state_reg <= FBH_DONE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        FBH_DONE: begin
          state_reg <= FBH_IDLE;
        end
        default: state_reg <= FBH_IDLE;
      endcase
    end
  end

  // ************************************
  // pin drive
  // ************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      chip_sel_n_out           <= 1'b1;
      out_en_n_out             <= 1'b1;
      write_n_out              <= 1'b1;
      id_high_voltage_line_out <= 1'b0;
      address_lines_out        <= '0;
      data_pins_out            <= 8'h00;
      data_pins_oe_out         <= 1'b0;
    end else if (state_reg == FBH_IDLE && req_valid_in) begin
      chip_sel_n_out           <= 1'b0;
      id_high_voltage_line_out <= (fbh_op_e'(req_op_in) == FBH_OP_ID_HV);
      if (fbh_op_e'(req_op_in) == FBH_OP_ID_HV) begin
        address_lines_out <= {{(ADDR_W-1){1'b0}}, req_addr_in[0]};
      end else begin
        address_lines_out <= req_addr_in;
      end
      // command bytes pass unchanged; their meaning belongs to the flash
      data_pins_out    <= req_data_in;
      data_pins_oe_out <= (fbh_op_e'(req_op_in) == FBH_OP_WRITE);
    end else if (state_reg == FBH_SETUP && cnt_reg <= 4'h1) begin
      if (op_reg == FBH_OP_WRITE) begin
        write_n_out <= 1'b0;
      end else begin
        out_en_n_out <= 1'b0;
      end
    end else if (state_reg == FBH_PULSE && cnt_reg <= 4'h1) begin
      write_n_out  <= 1'b1;
      out_en_n_out <= 1'b1;
    end else if (state_reg == FBH_HOLD && cnt_reg <= 4'h3) begin
      chip_sel_n_out           <= 1'b1;
      data_pins_oe_out         <= 1'b0;
      id_high_voltage_line_out <= 1'b0;
    end
  end

  // supply follows user request while idle; commands only land while it is high
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      program_supply_high_out <= 1'b0;
    end else if (state_reg == FBH_IDLE) begin
      program_supply_high_out <= prog_supply_high_req_in;
    end
  end

  // capture the pins sampled on the last strobe-low edge, two flops back;
  // one edge later the sync already holds the released bus
  logic read_cap;
  assign read_cap = (state_reg == FBH_HOLD) && (cnt_reg == 4'h2)
                    && (op_reg != FBH_OP_WRITE);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rsp_data_out  <= 8'h00;
      rsp_valid_out <= 1'b0;
    end else begin
      rsp_valid_out <= (state_reg == FBH_HOLD) && (cnt_reg <= 4'h1);
      if (read_cap) begin
        rsp_data_out <= din_sync_reg;
      end
    end
  end

  // ************************************
  // assertions
  // ************************************
  property p_rd_no_write;
    @(posedge sys_clk_in) disable iff (rst_in)
      !out_en_n_out |-> (write_n_out && !chip_sel_n_out);
  endproperty
  a_rd_no_write: assert property (p_rd_no_write) else $error("read strobe with write");

  property p_no_contention;
    @(posedge sys_clk_in) disable iff (rst_in)
      !out_en_n_out |-> !data_pins_oe_out;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("drive during read");

  property p_wr_select;
    @(posedge sys_clk_in) disable iff (rst_in)
      !write_n_out |-> (!chip_sel_n_out && out_en_n_out && data_pins_oe_out);
  endproperty
  a_wr_select: assert property (p_wr_select) else $error("write without select");

  property p_wr_pulse_len;
    @(posedge sys_clk_in) disable iff (rst_in)
      $fell(write_n_out) |-> !write_n_out [*2] ##1 write_n_out;
  endproperty
  a_wr_pulse_len: assert property (p_wr_pulse_len) else $error("write pulse length");

  property p_addr_stable;
    @(posedge sys_clk_in) disable iff (rst_in)
      !write_n_out |=> $stable(address_lines_out) && $stable(data_pins_out);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("bus moved in pulse");

  property p_id_addr;
    @(posedge sys_clk_in) disable iff (rst_in)
      id_high_voltage_line_out |-> (address_lines_out[ADDR_W-1:1] == '0);
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id address high bits");

  property p_idle_deselect;
    @(posedge sys_clk_in) disable iff (rst_in)
      (state_reg == FBH_IDLE) |-> chip_sel_n_out && !data_pins_oe_out;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect) else $error("selected when idle");

  property p_supply_stable;
    @(posedge sys_clk_in) disable iff (rst_in)
      !write_n_out |-> $stable(program_supply_high_out);
  endproperty
  a_supply_stable: assert property (p_supply_stable) else $error("supply moved in write");

  property p_rd_pulse_len;
    @(posedge sys_clk_in) disable iff (rst_in)
      $fell(out_en_n_out) |-> !out_en_n_out [*2] ##1 out_en_n_out;
  endproperty
  a_rd_pulse_len: assert property (p_rd_pulse_len) else $error("read pulse length");

  property p_sel_outlasts_strobe;
    @(posedge sys_clk_in) disable iff (rst_in)
      ($rose(write_n_out) || $rose(out_en_n_out)) |-> !chip_sel_n_out;
  endproperty
  a_sel_outlasts_strobe: assert property (p_sel_outlasts_strobe) else $error("select dropped early");

  property p_one_strobe;
    @(posedge sys_clk_in) disable iff (rst_in)
      !(!out_en_n_out && !write_n_out);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes at once");

  property p_standby_quiet;
    @(posedge sys_clk_in) disable iff (rst_in)
      chip_sel_n_out |-> (out_en_n_out && write_n_out && !data_pins_oe_out);
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("activity while deselected");

  property p_rsp_pulse;
    @(posedge sys_clk_in) disable iff (rst_in)
      rsp_valid_out |=> !rsp_valid_out;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than one cycle");
endmodule

// [dv/fbh_flash_model.sv]
// behavioural flash device answering the host controller's bus
`timescale 1ns/100ps
module fbh_flash_model #(
  parameter logic [7:0] MFR_ID = 8'h5A,  // arbitrary value
  parameter logic [7:0] DEV_ID = 8'hC3   // arbitrary value
) (
  input  wire logic [16:0] addr_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        hv_in,
  input  wire logic        vpp_in,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq_out,
  output logic             dq_oe_out
);
  logic [7:0]  mem [0:15];
  logic [7:0]  cmd_reg = 8'h00;
  logic [16:0] a_reg;
  initial for (int i = 0; i < 16; i++) mem[i] = 8'(i * 3 + 1);
  always @(negedge we_n_in) if (!ce_n_in) a_reg = addr_in;
  // programming only clears bits, as the real array does
  always @(posedge we_n_in) begin
    if (!ce_n_in && oe_n_in && vpp_in) begin
      if (cmd_reg == 8'h40) begin
        mem[a_reg[3:0]] = mem[a_reg[3:0]] & dq_in;
        cmd_reg = 8'h00;
      end else if (cmd_reg == 8'h20 && dq_in == 8'h20) begin
        foreach (mem[i]) mem[i] = 8'hFF;
        cmd_reg = 8'h00;
      end else if (cmd_reg == 8'hFF && dq_in == 8'hFF) cmd_reg = 8'h00;
      else cmd_reg = dq_in;
    end
  end
  assign dq_oe_out = !ce_n_in && !oe_n_in && we_n_in;
  // identifier bytes only answer with every other address line low
  assign dq_out = !(hv_in || cmd_reg == 8'h90) ? mem[addr_in[3:0]]
                : (addr_in[16:1] != 16'h0) ? 8'h00
                : addr_in[0] ? DEV_ID : MFR_ID;
endmodule

// [dv/test_fbh_host.sv]
// self-checking bench for the flash bus host controller
`timescale 1ns/100ps
module test_fbh_host;
  import fbh_pkg::*;
  localparam logic [7:0] MFR = 8'h5A;  // arbitrary value
  localparam logic [7:0] DEV = 8'hC3;  // arbitrary value
  logic clk = 1'b0, rst = 1'b1, v = 1'b0, vpp_req = 1'b0;
  logic [1:0] op = 2'h0;
  logic [ADDR_W-1:0] a = '0, ad;
  logic [7:0] d = 8'h00, rd, rsp_d, h_dq, d_dq, dq, last_bus = 8'h00;
  logic rdy, rsp_v, ce_n, oe_n, we_n, hv, vpp, h_oe, d_oe;
  int n_errors = 0, checks = 0;
  always #50 clk = ~clk;
  // released bus shows no stale value
  assign dq = h_oe ? h_dq : d_oe ? d_dq : ~last_bus;
  always @(posedge clk) if (h_oe || d_oe) last_bus <= dq;
  fbh_host u_dut (.sys_clk_in(clk), .rst_in(rst), .req_valid_in(v), .req_op_in(op),
    .req_addr_in(a), .req_data_in(d), .prog_supply_high_req_in(vpp_req),
    .req_ready_out(rdy), .rsp_valid_out(rsp_v), .rsp_data_out(rsp_d),
    .address_lines_out(ad), .chip_sel_n_out(ce_n), .out_en_n_out(oe_n),
    .write_n_out(we_n), .id_high_voltage_line_out(hv), .program_supply_high_out(vpp),
    .data_pins_out(h_dq), .data_pins_oe_out(h_oe), .data_pins_in(dq));
  fbh_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) u_flash (.addr_in(ad), .ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .hv_in(hv), .vpp_in(vpp), .dq_in(dq),
    .dq_out(d_dq), .dq_oe_out(d_oe));
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [1:0] o, input logic [16:0] ai, input logic [7:0] di);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    if (n == 20) begin
      n_errors++;
      $display("BAD ready expected 1 seen %b", rdy);
      final_report();
    end
    op = o; a = ai; d = di; v = 1'b1;
    @(negedge clk);
    v = 1'b0;
    n = 0;
    while (rsp_v !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    rd = rsp_d;
    // edges after the take: setup, pulse, hold, then two sync stages
    check("latency", 8'(SETUP_CYC + PULSE_CYC + HOLD_CYC + 4'h2), 8'(n));
    if (n == 20) final_report();
  endtask
  task automatic t_reset_read;
    xfer(2'h0, 17'h7, 8'h00);
    check("power-up read", 8'h16, rd);
    check("standby drive", 8'h00, {7'h0, d_oe});
    check("idle deselect", 8'h01, {7'h0, ce_n});
  endtask
  task automatic t_id_hv;
    xfer(2'h2, 17'h0, 8'h00);
    check("hv maker id", MFR, rd);
    xfer(2'h2, 17'h1, 8'h00);
    check("hv device id", DEV, rd);
    xfer(2'h2, 17'h1FFFE, 8'h00);
    check("hv masked addr", MFR, rd);
  endtask
  task automatic t_vpp_low;
    xfer(2'h1, 17'h0, 8'h90);
    check("supply low", 8'h00, {7'h0, vpp});
    xfer(2'h0, 17'h1, 8'h00);
    check("low supply cmd", 8'h04, rd);
  endtask
  task automatic t_cmd_id;
    @(negedge clk) vpp_req = 1'b1;
    xfer(2'h1, 17'h0, 8'h90);
    check("supply high", 8'h01, {7'h0, vpp});
    xfer(2'h0, 17'h0, 8'h00);
    check("cmd maker id", MFR, rd);
    xfer(2'h0, 17'h1, 8'h00);
    check("cmd device id", DEV, rd);
    xfer(2'h1, 17'h0, 8'h00);
    xfer(2'h0, 17'h1, 8'h00);
    check("read again", 8'h04, rd);
  endtask
  task automatic t_erase;
    int i;
    xfer(2'h1, 17'h0, 8'h20);
    xfer(2'h1, 17'h0, 8'h00);
    xfer(2'h0, 17'h5, 8'h00);
    check("single setup", 8'h10, rd);
    // every byte goes to zero before the array may be erased
    for (i = 0; i < 16; i++) begin
      xfer(2'h1, 17'h0, 8'h40);
      xfer(2'h1, 17'(i), 8'h00);
    end
    xfer(2'h0, 17'hC, 8'h00);
    check("zeroed", 8'h00, rd);
    xfer(2'h1, 17'h0, 8'h20);
    xfer(2'h1, 17'h0, 8'h20);
    xfer(2'h1, 17'h0, 8'h00);
    xfer(2'h0, 17'h5, 8'h00);
    check("erased", 8'hFF, rd);
    xfer(2'h0, 17'hC, 8'h00);
    check("erased whole", 8'hFF, rd);
  endtask
  task automatic t_program;
    xfer(2'h1, 17'h0, 8'h40);
    xfer(2'h1, 17'h5, 8'h3C);
    xfer(2'h1, 17'h0, 8'h00);
    xfer(2'h0, 17'h5, 8'h00);
    check("programmed", 8'h3C, rd);
    xfer(2'h0, 17'h4, 8'h00);
    check("neighbour", 8'hFF, rd);
  endtask
  task automatic t_cancel;
    xfer(2'h1, 17'h0, 8'h20);
    xfer(2'h1, 17'h0, 8'hFF);
    xfer(2'h1, 17'h0, 8'hFF);
    xfer(2'h1, 17'h0, 8'h00);
    xfer(2'h0, 17'h5, 8'h00);
    check("cancelled", 8'h3C, rd);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_reset_read();
    t_id_hv();
    t_vpp_low();
    t_cmd_id();
    t_erase();
    t_program();
    t_cancel();
    final_report();
  end
endmodule
